// [src/pipc_irq_ctrl.sv]
// Peripheral and external-pin interrupt enable, priority and edge logic
//
// Functional notes
// - Legacy mode: peripherals also need the gate bit
// - Three enable registers, reset zero, one enables
// - Enable A: parallel port down to timer1
// - Enable C: sync port 2 down to capcomp3
// - Three priority registers reset high
// - Priority A follows enable A layout
// - Priority B holes read zero, others high
// - Priority C follows enable C layout
// - Bit 7 enables two priority levels
// - Reset cause flags with own access rules
// - Pins edge-triggered, select bit picks edge
// - Selected edge sets pin flag; enable gates
// - Enabled pin wakes core from low power (here only pins already enabled at low-power entry)
// - Wake branches to vector only with global
// - Pins 1..3 priority from dedicated bits
// - Pin 0 is always high priority
// - Flags set regardless of enables
// - Control three holds pin 3..1 enables
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pipc_irq_ctrl
  import pipc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  // Register port request from the core
  input wire pipc_req_t regReq,
  // Read data, valid the cycle after a read strobe
  output logic [7:0] rdata_reg,
  // Peripheral flags: [7:0] set A, [15:8] B, [23:16] C
  input wire logic [23:0] periphFlags,
  // Asynchronous external interrupt pins
  input wire logic [3:0] extPin,
  // Core is in a power-managed mode
  input wire logic sleepMode,
  // High and low priority requests to the core
  output logic irqHigh_reg,
  output logic irqLow_reg,
  // Wake request and vector branch after wake
  output logic wakeReq_reg,
  output logic wakeBranch_reg
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Per-source request: flag and enable both set
  function automatic logic [27:0] reqOf(
    input logic [27:0] f,
    input logic [27:0] e
  );
    reqOf = f & e;
  endfunction : reqOf

  // Write merge keeping bits outside the mask at their old value
  function automatic logic [7:0] merge(
    input logic [7:0] old,
    input logic [7:0] wd,
    input logic [7:0] msk
  );
    merge = (wd & msk) | (old & ~msk);
  endfunction : merge

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] en_reg [3]; // Peripheral enables
  logic [7:0] pri_reg [3]; // Peripheral priorities
  logic [7:0] rcause_reg; // Reset cause and priority enable
  logic [7:0] ctl2_reg; // Edge selects, pin 3 priority
  logic [7:0] ctl3_reg; // Pin 1..2 priority, pin 1..3 enables, flags
  logic [7:0] ctl1_reg; // Global, gate, pin 0 enable and flag
  logic [3:0] sync1_reg; // Pin synchroniser stage one
  logic [3:0] sync2_reg; // Stage two
  logic [3:0] sync3_reg; // Stage three
  logic [3:0] pinLevel_reg; // Settled pin level, moves once stages agree
  logic [3:0] armed_reg; // Enables latched at low-power entry
  logic sleepPrev_reg; // Previous sleep level
  logic [3:0] pinEdge; // Selected edge seen per pin
  logic [3:0] pinFlag; // Pin flags gathered
  logic [3:0] pinEn; // Pin enables gathered
  logic [3:0] pinPri; // Pin priorities gathered
  logic [27:0] allReq; // All source requests
  logic [27:0] allPri; // All source priorities
  logic prioEn; // Two-level mode
  logic global_irq_enable; // Global enable (high level in two-level mode)
  logic pGate; // Peripheral gate (low level in two-level mode)
  logic wrHit [10]; // Write decode per offset

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Write strobe per register offset
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      wrHit[i] = regReq.wr && (regReq.addr == 4'(i));
    end
  end

  // ---------------------------------------------------------------
  // Peripheral enable and priority registers
  // ---------------------------------------------------------------
  // Software writes only implemented bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        en_reg[i] <= RST_EN;
        pri_reg[i] <= RST_PRI & ((i == 1) ? MASK_B : MASK_FULL);
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        // Set B carries holes, A and C are full width
        if (wrHit[i]) begin
          en_reg[i] <= merge(en_reg[i], regReq.wdata,
            (i == 1) ? MASK_B : MASK_FULL);
        end
        if (wrHit[i + 3]) begin
          pri_reg[i] <= merge(pri_reg[i], regReq.wdata,
            (i == 1) ? MASK_B : MASK_FULL);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Reset cause and priority enable register
  // ---------------------------------------------------------------
  // Timeout and power-down bits are read-only to software
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rcause_reg <= RST_RCAUSE;
    end else if (wrHit[OFF_RCAUSE]) begin
      rcause_reg <= merge(rcause_reg, regReq.wdata,
        MASK_RCAUSE_WR);
    end
  end

  assign prioEn = rcause_reg[BIT_PRIO_EN];

  // ---------------------------------------------------------------
  // Pin synchroniser and edge detect
  // ---------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      pinLevel_reg <= 4'h0; // Matches the idle pin level
    end else begin
      sync1_reg <= extPin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      // Follow the pin only where stages two and three agree
      pinLevel_reg <= (sync2_reg & sync3_reg) |
        (pinLevel_reg & (sync2_reg ^ sync3_reg));
    end
  end

  // Rising when select is one, falling when zero
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      if (sync2_reg[p] != sync3_reg[p]) begin
        pinEdge[p] = 1'b0; // Stages still disagree, no change yet
      end else if (ctl2_reg[BIT_EDGE0 - p]) begin
        pinEdge[p] = sync3_reg[p] & ~pinLevel_reg[p];
      end else begin
        pinEdge[p] = ~sync3_reg[p] & pinLevel_reg[p];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers one, two and three
  // ---------------------------------------------------------------
  // Flags: an edge in the clearing cycle still sets the flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl1_reg <= RST_CTL_ONE;
    end else begin
      if (wrHit[OFF_CTL_ONE]) begin
        ctl1_reg <= merge(ctl1_reg, regReq.wdata, MASK_CTL_ONE);
      end
      if (pinEdge[0]) begin
        ctl1_reg[BIT_P0_FLAG] <= 1'b1;
      end
    end
  end

  // Edge selects and pin 3 priority
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl2_reg <= RST_CTL_TWO;
    end else if (wrHit[OFF_CTL_TWO]) begin
      ctl2_reg <= merge(ctl2_reg, regReq.wdata,
        MASK_CTL_TWO);
    end
  end

  // Pin 1..2 priority, pin 1..3 enables and flags
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl3_reg <= RST_CTL_THREE;
    end else begin
      if (wrHit[OFF_CTL_THREE]) begin
        ctl3_reg <= regReq.wdata;
      end
      for (int p = 1; p < NUM_PINS; p++) begin
        if (pinEdge[p]) begin
          ctl3_reg[p - 1] <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Gathered pin fields
  // ---------------------------------------------------------------
  always_comb begin
    pinFlag = {ctl3_reg[2:0], ctl1_reg[BIT_P0_FLAG]};
    pinEn = {ctl3_reg[BIT_PEN_LO +: 3], ctl1_reg[BIT_P0_EN]};
    pinPri = {ctl2_reg[BIT_P3_PRI], ctl3_reg[BIT_P2_PRI],
      ctl3_reg[BIT_P1_PRI], 1'b1};
  end

  assign global_irq_enable = ctl1_reg[BIT_GIE];
  assign pGate = ctl1_reg[BIT_PGATE];
  assign allReq = reqOf({periphFlags, pinFlag},
    {en_reg[2], en_reg[1], en_reg[0], pinEn});
  assign allPri = {pri_reg[2], pri_reg[1], pri_reg[0], pinPri};

  // ---------------------------------------------------------------
  // Request routing
  // ---------------------------------------------------------------
  // Legacy: one level; two-level: split by priority bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqHigh_reg <= 1'b0;
      irqLow_reg <= 1'b0;
    end else if (!prioEn) begin
      irqHigh_reg <= global_irq_enable && ((|allReq[3:0]) ||
        (pGate && (|allReq[27:4])));
      irqLow_reg <= 1'b0;
    end else begin
      irqHigh_reg <= global_irq_enable && (|(allReq & allPri));
      irqLow_reg <= global_irq_enable && pGate &&
        (|(allReq & ~allPri));
    end
  end

  // ---------------------------------------------------------------
  // Wake from power-managed mode
  // ---------------------------------------------------------------
  // Enables are caught at entry; later enables do not wake
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleepPrev_reg <= 1'b0;
      armed_reg <= 4'h0;
      wakeReq_reg <= 1'b0;
      wakeBranch_reg <= 1'b0;
    end else begin
      sleepPrev_reg <= sleepMode;
      if (sleepMode && !sleepPrev_reg) begin
        armed_reg <= pinEn;
      end
      wakeReq_reg <= sleepMode && sleepPrev_reg &&
        (|(pinFlag & armed_reg));
      wakeBranch_reg <= sleepMode && sleepPrev_reg && global_irq_enable &&
        (|(pinFlag & armed_reg));
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else if (!regReq.rd) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (regReq.addr)
        OFF_EN_A: rdata_reg <= en_reg[0];
        OFF_EN_B: rdata_reg <= en_reg[1];
        OFF_EN_C: rdata_reg <= en_reg[2];
        OFF_PRI_A: rdata_reg <= pri_reg[0];
        OFF_PRI_B: rdata_reg <= pri_reg[1];
        OFF_PRI_C: rdata_reg <= pri_reg[2];
        OFF_RCAUSE: rdata_reg <= rcause_reg;
        OFF_CTL_TWO: rdata_reg <= ctl2_reg;
        OFF_CTL_THREE: rdata_reg <= ctl3_reg;
        OFF_CTL_ONE: rdata_reg <= ctl1_reg;
        default: rdata_reg <= 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_LEGACY_GATE: assert property (
    !prioEn && !pGate && (allReq[3:0] == 4'h0) |=> !irqHigh_reg)
    else $error("peripheral passed without gate");

  AST_HOLES_ZERO: assert property (
    regReq.rd && (regReq.addr == OFF_EN_B) |=>
      (rdata_reg[5:4] == 2'b00) && !rdata_reg[2])
    else $error("enable B hole read nonzero");

  AST_EN_WRITE: assert property (
    wrHit[OFF_EN_A] ##1 regReq.rd && (regReq.addr == OFF_EN_A)
      && !wrHit[OFF_EN_A] |=> rdata_reg == $past(regReq.wdata, 2))
    else $error("enable A readback mismatch");

  AST_LEGACY_NO_LOW: assert property (
    !$past(prioEn) |-> !irqLow_reg)
    else $error("low request in legacy mode");

  AST_RO_CAUSE: assert property (
    wrHit[OFF_RCAUSE] |=> $stable(rcause_reg[BIT_TO:BIT_PD]))
    else $error("read-only cause bit written");

  AST_RISE_FLAG: assert property (
    ctl2_reg[BIT_EDGE0] && (sync2_reg[0] == sync3_reg[0]) &&
      sync3_reg[0] && !pinLevel_reg[0] |=> ctl1_reg[BIT_P0_FLAG])
    else $error("pin 0 edge lost");

  AST_FLAG_STICKY: assert property (
    ctl3_reg[0] && !wrHit[OFF_CTL_THREE] |=> ctl3_reg[0])
    else $error("pin 1 flag dropped");

  AST_PIN0_HIGH: assert property (
    prioEn && global_irq_enable && allReq[0] |=> irqHigh_reg)
    else $error("pin 0 not high priority");

  AST_WAKE_BRANCH: assert property (
    wakeBranch_reg |-> wakeReq_reg && $past(global_irq_enable))
    else $error("branch without global enable");

  AST_WAKE_ARMED: assert property (
    wakeReq_reg |-> $past(sleepMode, 2) && $past(sleepMode))
    else $error("wake outside low power");

endmodule : pipc_irq_ctrl
`default_nettype wire

// [src/pipc_pkg.sv]
// Package: register map, field positions and carriers of the irq control
package pipc_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFF_EN_A = 4'h0;
  localparam logic [3:0] OFF_EN_B = 4'h1;
  localparam logic [3:0] OFF_EN_C = 4'h2;
  localparam logic [3:0] OFF_PRI_A = 4'h3;
  localparam logic [3:0] OFF_PRI_B = 4'h4;
  localparam logic [3:0] OFF_PRI_C = 4'h5;
  localparam logic [3:0] OFF_RCAUSE = 4'h6;
  localparam logic [3:0] OFF_CTL_TWO = 4'h7;
  localparam logic [3:0] OFF_CTL_THREE = 4'h8;
  localparam logic [3:0] OFF_CTL_ONE = 4'h9;
  // ---------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_B = 8'hCB;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [7:0] RST_PRI = 8'hFF;
  localparam logic [7:0] MASK_RCAUSE_WR = 8'h93;
  localparam logic [7:0] RST_RCAUSE = 8'h1C;
  localparam logic [7:0] MASK_CTL_TWO = 8'h7A;
  localparam logic [7:0] RST_CTL_TWO = 8'h7A;
  localparam logic [7:0] RST_CTL_THREE = 8'hC0;
  localparam logic [7:0] MASK_CTL_ONE = 8'hD2;
  localparam logic [7:0] RST_CTL_ONE = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_PRIO_EN = 7;
  localparam int BIT_RI = 4;
  localparam int BIT_TO = 3;
  localparam int BIT_PD = 2;
  localparam int BIT_GIE = 7;
  localparam int BIT_PGATE = 6;
  localparam int BIT_P0_EN = 4;
  localparam int BIT_P0_FLAG = 1;
  localparam int BIT_EDGE0 = 6;
  localparam int BIT_P3_PRI = 1;
  localparam int BIT_P2_PRI = 7;
  localparam int BIT_P1_PRI = 6;
  localparam int BIT_PEN_LO = 3;
  localparam int NUM_PINS = 4;
  // ---------------------------------------------------------------
  // Register bus request carrier
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pipc_req_t;
endpackage : pipc_pkg

// [verification/pipc_far_model.sv]
// Far-side model: peripheral flag sources, external pins and core sleep
`timescale 1ns/1ps
`default_nettype none
module pipc_far_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [23:0] flagCmd,
  input wire logic [3:0] pinCmd,
  input wire logic sleepCmd,
  output logic [23:0] periphFlags,
  output logic [3:0] extPin,
  output logic sleepMode
);
  // ---------------------------------------------------------------
  // Sources change just after a rising edge and hold for many cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      periphFlags <= 24'h000000;
      extPin <= 4'h0;
      sleepMode <= 1'b0;
    end else begin
      // Flags are levels, held until the source drops them
      periphFlags <= flagCmd;
      // Pin levels never pulse shorter than a clock
      extPin <= pinCmd;
      // Core enters and leaves the power-managed mode
      sleepMode <= sleepCmd;
    end
  end
endmodule : pipc_far_model
`default_nettype wire

// [verification/pipc_irq_ctrl_tb.sv]
// Self-checking bench for the peripheral and pin interrupt control
`timescale 1ns/1ps
`default_nettype none
module pipc_irq_ctrl_tb
  import pipc_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic reset = 1'b1;
  pipc_req_t regReq = '0;
  logic [23:0] flagCmd = 24'h000000;
  logic [3:0] pinCmd = 4'h0;
  logic sleepCmd = 1'b0;
  logic [7:0] rdata_reg;
  logic [23:0] periphFlags;
  logic [3:0] extPin;
  logic sleepMode;
  logic irqHigh_reg;
  logic irqLow_reg;
  logic wakeReq_reg;
  logic wakeBranch_reg;
  int fail_count = 0;
  int check_count = 0;
  // Expected contents after reset and after writing all ones
  logic [7:0] rstVal [10] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hCB, 8'hFF,
    8'h1C, 8'h7A, 8'hC0, 8'h00};
  logic [7:0] oneVal [10] = '{8'hFF, 8'hCB, 8'hFF, 8'hFF, 8'hCB, 8'hFF,
    8'h9F, 8'h7A, 8'hFF, 8'hD2};
  logic [7:0] en;
  logic hit;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  pipc_far_model far (.clk(clk), .reset(reset), .flagCmd(flagCmd),
    .pinCmd(pinCmd), .sleepCmd(sleepCmd), .periphFlags(periphFlags),
    .extPin(extPin), .sleepMode(sleepMode));
  pipc_irq_ctrl dut (.clk(clk), .reset(reset), .regReq(regReq),
    .rdata_reg(rdata_reg), .periphFlags(periphFlags), .extPin(extPin),
    .sleepMode(sleepMode), .irqHigh_reg(irqHigh_reg),
    .irqLow_reg(irqLow_reg), .wakeReq_reg(wakeReq_reg),
    .wakeBranch_reg(wakeBranch_reg));
  // ---------------------------------------------------------------
  // Bus cycles and comparisons
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    #1 chk(rdata_reg, exp);
  endtask : rdchk
  // Write then read back with no gap between the two strobes
  task automatic wrrd(input logic [3:0] a, input logic [7:0] d,
    input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq <= '0;
    #1 chk(rdata_reg, exp);
  endtask : wrrd
  // Outputs compared as {high, low, wake, branch} once settled
  task automatic irqchk(input logic [3:0] exp);
    repeat (8) @(posedge clk);
    #1 chk({4'h0, irqHigh_reg, irqLow_reg, wakeReq_reg, wakeBranch_reg},
      {4'h0, exp});
  endtask : irqchk
  task automatic do_reset();
    reset <= 1'b1;
    flagCmd <= 24'h000000;
    pinCmd <= 4'h0;
    sleepCmd <= 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
  endtask : do_reset
  // Move the pins, then compare both pin flag registers
  task automatic pinstep(input logic [3:0] v, input logic [7:0] f0,
    input logic [7:0] f3);
    @(posedge clk);
    pinCmd <= v;
    repeat (8) @(posedge clk);
    rdchk(OFF_CTL_ONE, f0);
    rdchk(OFF_CTL_THREE, f3);
  endtask : pinstep
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 10; i++) begin
      rdchk(4'(i), rstVal[i]);
    end
    @(posedge clk);
    #1 chk(rdata_reg, 8'h00);
    for (int i = 0; i < 10; i++) begin
      wr(4'(i), 8'hFF);
    end
    for (int i = 0; i < 10; i++) begin
      rdchk(4'(i), oneVal[i]);
    end
    // Unmapped places are written with ones and must stay empty
    for (int i = 0; i < 16; i++) begin
      wr(4'(i), (i > 9) ? 8'hFF : 8'h00);
    end
    for (int i = 0; i < 16; i++) begin
      rdchk(4'(i), (i == 6) ? 8'h0C : 8'h00);
    end
    // Back-to-back write and read of the enable registers
    wrrd(OFF_EN_A, 8'hA5, 8'hA5);
    wrrd(OFF_EN_B, 8'hFF, 8'hCB);
    wrrd(OFF_EN_C, 8'h5A, 8'h5A);
  endtask : t_regs
  // Single-level mode: peripherals pass only through the gate
  task automatic t_legacy();
    do_reset();
    wr(OFF_EN_A, 8'h01);
    wr(OFF_CTL_ONE, 8'h80);
    @(posedge clk);
    flagCmd <= 24'h000001;
    irqchk(4'h0);
    wr(OFF_CTL_ONE, 8'hC0);
    irqchk(4'h8);
    // Every enable bit against its own flag and all the others
    for (int i = 0; i < 24; i++) begin
      en = 8'h01 << (i % 8);
      hit = (i / 8 == 1) ? en[0] | (|(en & 8'hCB)) : 1'b1;
      hit = (i / 8 == 1) ? |(en & 8'hCB) : hit;
      wr(OFF_EN_A + 4'(i / 8), en);
      @(posedge clk);
      flagCmd <= 24'h000001 << i;
      irqchk({hit, 3'b000});
      @(posedge clk);
      flagCmd <= ~(24'h000001 << i);
      irqchk(4'h0);
      wr(OFF_EN_A + 4'(i / 8), 8'h00);
    end
  endtask : t_legacy
  // Two-level mode routes by the priority bit
  task automatic t_prio();
    do_reset();
    wr(OFF_RCAUSE, 8'h80);
    wr(OFF_CTL_ONE, 8'h80);
    wr(OFF_EN_A, 8'h01);
    @(posedge clk);
    flagCmd <= 24'h000001;
    irqchk(4'h8);
    wr(OFF_PRI_A, 8'hFE);
    irqchk(4'h0);
    wr(OFF_CTL_ONE, 8'hC0);
    irqchk(4'h4);
    wr(OFF_RCAUSE, 8'h00);
    irqchk(4'h8);
  endtask : t_prio
  // Edges set flags with all enables off, both edge senses
  task automatic t_pins();
    do_reset();
    pinstep(4'hF, 8'h02, 8'hC7);
    irqchk(4'h0);
    wr(OFF_CTL_TWO, 8'h00);
    wr(OFF_CTL_ONE, 8'h00);
    wr(OFF_CTL_THREE, 8'hC0);
    pinstep(4'h0, 8'h02, 8'hC7);
    wr(OFF_CTL_ONE, 8'h00);
    wr(OFF_CTL_THREE, 8'hC0);
    pinstep(4'hF, 8'h00, 8'hC0);
  endtask : t_pins
  // Pin priorities: pin 0 fixed high, pins 1..3 from their bits
  task automatic t_pinpri();
    do_reset();
    wr(OFF_RCAUSE, 8'h80);
    wr(OFF_CTL_ONE, 8'h92);
    irqchk(4'h8);
    wr(OFF_CTL_ONE, 8'hC0);
    wr(OFF_CTL_THREE, 8'h89);
    irqchk(4'h4);
    wr(OFF_CTL_THREE, 8'hC9);
    irqchk(4'h8);
    wr(OFF_CTL_THREE, 8'h52);
    irqchk(4'h4);
    wr(OFF_CTL_THREE, 8'hE4);
    irqchk(4'h8);
    wr(OFF_CTL_TWO, 8'h78);
    irqchk(4'h4);
  endtask : t_pinpri
  // Wake needs the enable armed before sleep; branch needs global
  task automatic t_wake();
    for (int k = 0; k < 3; k++) begin
      do_reset();
      if (k < 2) begin
        wr(OFF_CTL_ONE, (k == 1) ? 8'h90 : 8'h10);
      end
      @(posedge clk);
      sleepCmd <= 1'b1;
      if (k == 2) begin
        wr(OFF_CTL_ONE, 8'h10);
      end
      @(posedge clk);
      pinCmd <= 4'h1;
      irqchk((k == 0) ? 4'h2 : (k == 1) ? 4'hB : 4'h0);
    end
  endtask : t_wake
  // ---------------------------------------------------------------
  // Verdict and main sequence
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  initial begin
    do_reset();
    t_regs();
    t_legacy();
    t_prio();
    t_pins();
    t_pinpri();
    t_wake();
    close_out();
  end
  // Cuts a hang short
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule : pipc_irq_ctrl_tb
`default_nettype wire
